/* File: hdl/sbi_pkg.sv */
// ------------------------------------------------------------
// system bus interface constants and carriers
// ------------------------------------------------------------
package sbi_pkg;
    // register byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h8;
    localparam logic [3:0] REG_INFO = 4'hc;
    // control field positions and reset value
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_PAT_LSB = 3;
    localparam int CTRL_FAST_BIT = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // status and mask bit positions
    localparam int EV_CACHE_ERR = 0;
    localparam int EV_BUS_ERR = 1;
    localparam int EV_WB_BADPAR = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    // timing and sizing counts
    localparam logic [2:0] DIV_RSV_ENC = 3'h7;
    localparam logic [3:0] PAT_LAST_ENC = 4'h8;
    localparam logic [1:0] COMPAT_GAP = 2'h2;
    localparam logic [2:0] BLK_DWORDS = 3'h4;
    localparam int WBUF_DEPTH = 4;
    // writeback pacing: slot length and data-slot mask per encoding 0..8
    localparam logic [8:0][2:0] PAT_LEN = {3'h7, 3'h7, 3'h3, 3'h6, 3'h5, 3'h2, 3'h4, 3'h3, 3'h1};
    localparam logic [8:0][6:0] PAT_MASK = {7'h09, 7'h03, 7'h01, 7'h03, 7'h03, 7'h01, 7'h03,
                                            7'h03, 7'h01};

    // bus sequencer states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b011,
        ST_GAP = 3'b010,
        ST_RWAIT = 3'b110
    } sbi_state_e;

    // cycle kind shown on the command pins; also the operation in flight
    typedef enum logic [1:0] {
        CMD_DATA = 2'b00,
        CMD_READ = 2'b01,
        CMD_WRITE = 2'b10,
        CMD_BLKW = 2'b11
    } sbi_cmd_e;

    // one bus cycle as driven on the pins
    typedef struct packed {
        logic [63:0] data;
        logic [7:0] chk;
        logic valid;
        sbi_cmd_e cmd;
        logic oe;
    } sbi_cycle_s;
endpackage : sbi_pkg

/* File: hdl/sbi_top.sv */
// Notes on behaviour
// - fast mode writes every 2, compat 4
// - address cycle bits 63:56 carry vaddr 19:12
// - uncached stores queue in four-entry buffer
// - check bits zero off data; cmd parity zero
// - writeback parity error sent bad, no exception
// - only first read doubleword error bit checked
// - bad read parity stored; exception if awaited
// - block write data right after address
// - bus released right after read request
// - idle writeback slots hold last data value
// - trailing idle slots of pattern complete
// - test serial output wired to serial input
// - reserved feedback and mismatch outputs high
// - bus clock is pipeline clock divided 2..8
// - writeback paced by selectable slot pattern
`timescale 1ns/1ps
module sbi_top #(
    parameter int DEPTH = sbi_pkg::WBUF_DEPTH
) (
    input wire logic CLK, // pipeline clock
    input wire logic RSTN, // async reset, low active
    input wire logic [3:0] REG_ADDR, // register byte address
    input wire logic [31:0] REG_WDATA, // register write data
    input wire logic REG_WR, // write strobe
    input wire logic REG_RD, // read strobe
    output logic [31:0] REG_RDATA, // read data, cycle after strobe
    output logic IRQ, // unmasked status pending
    input wire logic ST_VALID, // uncached store offered
    input wire logic [35:0] ST_ADDR, // store physical address
    input wire logic [7:0] ST_VTAG, // store vaddr 19:12
    input wire logic [63:0] ST_DATA, // store doubleword
    output logic ST_READY, // store taken
    input wire logic WB_VALID, // writeback offered
    input wire logic [35:0] WB_ADDR, // writeback address
    input wire logic [7:0] WB_VTAG, // writeback vaddr 19:12
    input wire logic [255:0] WB_DATA, // four doublewords, first low
    input wire logic [3:0] WB_BADPAR, // cache parity error per dword
    output logic WB_READY, // writeback taken
    input wire logic RD_VALID, // block read offered
    input wire logic [35:0] RD_ADDR, // read address
    input wire logic [7:0] RD_VTAG, // read vaddr 19:12
    output logic RD_READY, // read taken
    output logic FILL_VALID, // one response dword to cache
    output logic [63:0] FILL_DATA, // response data
    output logic [7:0] FILL_CHECK, // received check bits
    output logic [1:0] FILL_INDEX, // dword number in block
    output logic EXC_CACHE_ERR, // cache error exception pulse
    output logic EXC_BUS_ERR, // bus error exception pulse
    output logic SCLK_OUT, // divided system bus clock
    input wire logic [63:0] SYS_ADDR_DATA_BUS_I, // bus pin level
    output logic [63:0] SYS_ADDR_DATA_BUS_O, // bus drive value
    output logic SYS_ADDR_DATA_BUS_OE, // bus driven
    input wire logic [7:0] SYS_CHECK_BUS_I, // check pin level
    output logic [7:0] SYS_CHECK_BUS_O, // check drive value
    output logic SYS_CHECK_BUS_OE, // check driven
    output logic SYS_VALID_OUT, // cycle carries address or data
    output logic [1:0] SYS_CMD_OUT, // cycle kind
    output logic SYS_CMD_PARITY, // command parity
    input wire logic RESP_VALID, // response dword on bus
    input wire logic RESP_ERR, // data identifier error bit
    input wire logic TDI, // test serial in
    output logic TDO, // test serial out
    output logic SLEW_FEEDBACK_OUT, // reserved output
    output logic MISMATCH_FLAG_OUT // reserved output
);
    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cnt;
        logic sclk;
        logic [63:0] ad_m;
        logic [63:0] ad_s;
        logic [7:0] ck_m;
        logic [7:0] ck_s;
        logic [1:0] rv_m;
        logic [1:0] rv_s;
        sbi_pkg::sbi_state_e st;
        sbi_pkg::sbi_cmd_e op;
        logic [35:0] addr;
        logic [7:0] vtag;
        logic [3:0][63:0] blk;
        logic [3:0] badpar;
        logic [2:0] sent;
        logic [2:0] pos;
        logic [1:0] gap;
        logic [DEPTH-1:0][63:0] wb_data;
        logic [DEPTH-1:0][35:0] wb_addr;
        logic [DEPTH-1:0][7:0] wb_vtag;
        logic [PW-1:0] rd_p;
        logic [PW-1:0] wr_p;
        logic [PW:0] cnt_w;
        sbi_pkg::sbi_cycle_s bus;
        logic fill_v;
        logic [63:0] fill_d;
        logic [7:0] fill_c;
        logic [1:0] fill_i;
        logic exc_c;
        logic exc_b;
        logic [7:0] ctrl;
        logic [sbi_pkg::EV_W-1:0] stat;
        logic [sbi_pkg::EV_W-1:0] mask;
        logic [31:0] rdata;
        logic irq;
    } sbi_regs_s;

    sbi_regs_s s, n;
    logic [1:0] rst_q;
    logic rst_n;
    logic tick, go, push, pop, start_ok, slot_d, fast;
    logic [2:0] lim, enc_d, pat_len;
    logic [3:0] pat_enc;
    logic [63:0] tx_word;
    logic [7:0] par_out, par_in, tx_chk;
    logic [sbi_pkg::EV_W-1:0] ev, w1c;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 2");
    end

    // reset release through two flops
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // ------------------------------------------------------------
    // clock divider, pacing pattern, parity
    // ------------------------------------------------------------
    assign enc_d = s.ctrl[sbi_pkg::CTRL_DIV_LSB +: 3];
    assign lim = (enc_d == sbi_pkg::DIV_RSV_ENC) ? 3'h7 : enc_d + 3'h1;
    assign tick = (s.cnt == lim);
    assign fast = s.ctrl[sbi_pkg::CTRL_FAST_BIT];
    assign pat_enc = (s.ctrl[sbi_pkg::CTRL_PAT_LSB +: 4] > sbi_pkg::PAT_LAST_ENC) ? 4'h0
                   : s.ctrl[sbi_pkg::CTRL_PAT_LSB +: 4];
    assign pat_len = sbi_pkg::PAT_LEN[pat_enc];
    assign slot_d = sbi_pkg::PAT_MASK[pat_enc][s.pos];
    assign tx_word = (s.op == sbi_pkg::CMD_WRITE) ? s.wb_data[s.rd_p] : s.blk[s.sent[1:0]];
    assign tx_chk = par_out ^ {8{s.op == sbi_pkg::CMD_BLKW && s.badpar[s.sent[1:0]]}};

    // byte parity out and in
    for (genvar i = 0; i < 8; i++) begin : g_par
        assign par_out[i] = ^tx_word[8*i +: 8];
        assign par_in[i] = ^s.ad_s[8*i +: 8];
    end

    // handshakes
    assign start_ok = (s.st == sbi_pkg::ST_IDLE)
                    || (s.st == sbi_pkg::ST_DATA && s.op == sbi_pkg::CMD_WRITE && fast)
                    || (s.st == sbi_pkg::ST_GAP && s.gap == 2'h0);
    assign ST_READY = (s.cnt_w < (PW + 1)'(DEPTH));
    assign push = ST_VALID && ST_READY;
    assign pop = tick && s.st == sbi_pkg::ST_ADDR && s.op == sbi_pkg::CMD_WRITE;
    assign WB_READY = tick && start_ok;
    assign RD_READY = tick && start_ok && !WB_VALID && s.cnt_w == '0;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        go = 1'b0;
        ev = '0;
        w1c = '0;
        n.ad_m = SYS_ADDR_DATA_BUS_I;
        n.ad_s = s.ad_m;
        n.ck_m = SYS_CHECK_BUS_I;
        n.ck_s = s.ck_m;
        n.rv_m = {RESP_ERR, RESP_VALID};
        n.rv_s = s.rv_m;
        n.cnt = tick ? 3'h0 : s.cnt + 3'h1;
        n.sclk = ({1'b0, n.cnt} < ({1'b0, lim} + 4'h1) >> 1);
        n.fill_v = 1'b0;
        n.exc_c = 1'b0;
        n.exc_b = 1'b0;
        n.rdata = '0;
        // store buffer fill side
        if (push) begin
            n.wb_data[s.wr_p] = ST_DATA;
            n.wb_addr[s.wr_p] = ST_ADDR;
            n.wb_vtag[s.wr_p] = ST_VTAG;
            n.wr_p = s.wr_p + PW'(1);
        end
        if (pop) begin
            n.rd_p = s.rd_p + PW'(1);
        end
        n.cnt_w = s.cnt_w + (PW + 1)'(push) - (PW + 1)'(pop);
        // bus sequencer, one step per bus clock
        if (tick) begin
            unique case (s.st)
                sbi_pkg::ST_IDLE: begin
                    n.bus.oe = 1'b0;
                    n.bus.valid = 1'b0;
                    n.bus.chk = 8'h00;
                end
                sbi_pkg::ST_ADDR: begin
                    if (s.op == sbi_pkg::CMD_READ) begin
                        n.bus.oe = 1'b0;
                        n.bus.valid = 1'b0;
                        n.bus.chk = 8'h00;
                        n.st = sbi_pkg::ST_RWAIT;
                    end else begin
                        n.bus.data = tx_word;
                        n.bus.chk = tx_chk;
                        n.bus.valid = 1'b1;
                        n.bus.cmd = sbi_pkg::CMD_DATA;
                        n.sent = 3'h1;
                        n.pos = (pat_len == 3'h1) ? 3'h0 : 3'h1;
                        n.st = sbi_pkg::ST_DATA;
                        ev[sbi_pkg::EV_WB_BADPAR] = s.op == sbi_pkg::CMD_BLKW && s.badpar[0];
                    end
                end
                sbi_pkg::ST_DATA: begin
                    n.bus.valid = 1'b0;
                    n.bus.chk = 8'h00;
                    if (s.op == sbi_pkg::CMD_WRITE) begin
                        n.st = sbi_pkg::ST_GAP;
                        n.gap = sbi_pkg::COMPAT_GAP - 2'h1;
                    end else if (s.sent == sbi_pkg::BLK_DWORDS && s.pos == 3'h0) begin
                        n.st = sbi_pkg::ST_IDLE;
                        n.bus.oe = 1'b0;
                    end else begin
                        if (slot_d && s.sent < sbi_pkg::BLK_DWORDS) begin
                            n.bus.data = tx_word;
                            n.bus.chk = tx_chk;
                            n.bus.valid = 1'b1;
                            n.sent = s.sent + 3'h1;
                            ev[sbi_pkg::EV_WB_BADPAR] = s.badpar[s.sent[1:0]];
                        end
                        n.pos = (s.pos == pat_len - 3'h1) ? 3'h0 : s.pos + 3'h1;
                    end
                end
                sbi_pkg::ST_GAP: begin
                    n.gap = s.gap - 2'h1;
                    if (s.gap == 2'h0) begin
                        n.st = sbi_pkg::ST_IDLE;
                        n.bus.oe = 1'b0;
                    end
                end
                sbi_pkg::ST_RWAIT: begin
                    if (s.rv_s[0]) begin
                        n.fill_v = 1'b1;
                        n.fill_d = s.ad_s;
                        n.fill_c = s.ck_s;
                        n.fill_i = s.sent[1:0];
                        if (s.sent == 3'h0) begin
                            n.exc_b = s.rv_s[1];
                            n.exc_c = par_in != s.ck_s;
                            ev[sbi_pkg::EV_BUS_ERR] = s.rv_s[1];
                            ev[sbi_pkg::EV_CACHE_ERR] = par_in != s.ck_s;
                        end
                        n.sent = s.sent + 3'h1;
                        if (s.sent == sbi_pkg::BLK_DWORDS - 3'h1) begin
                            n.st = sbi_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    n.st = sbi_pkg::ST_IDLE;
                end
            endcase
            // start next operation: writeback, buffered stores, then read
            if (start_ok) begin
                go = 1'b1;
                if (WB_VALID) begin
                    n.op = sbi_pkg::CMD_BLKW;
                    n.addr = WB_ADDR;
                    n.vtag = WB_VTAG;
                    n.blk = WB_DATA;
                    n.badpar = WB_BADPAR;
                end else if (s.cnt_w != '0) begin
                    n.op = sbi_pkg::CMD_WRITE;
                    n.addr = s.wb_addr[s.rd_p];
                    n.vtag = s.wb_vtag[s.rd_p];
                end else if (RD_VALID) begin
                    n.op = sbi_pkg::CMD_READ;
                    n.addr = RD_ADDR;
                    n.vtag = RD_VTAG;
                end else begin
                    go = 1'b0;
                end
                if (go) begin
                    n.st = sbi_pkg::ST_ADDR;
                    n.sent = 3'h0;
                    n.pos = 3'h0;
                    n.bus = '{data: {n.vtag, 20'h0_0000, n.addr}, chk: 8'h00, valid: 1'b1,
                              cmd: n.op, oe: 1'b1};
                end
            end
        end
        // register port
        if (REG_WR) begin
            unique case (REG_ADDR)
                sbi_pkg::REG_CTRL: n.ctrl = REG_WDATA[7:0];
                sbi_pkg::REG_STATUS: w1c = REG_WDATA[sbi_pkg::EV_W-1:0];
                sbi_pkg::REG_MASK: n.mask = REG_WDATA[sbi_pkg::EV_W-1:0];
                default: ;
            endcase
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                sbi_pkg::REG_CTRL: n.rdata = {24'h00_0000, s.ctrl};
                sbi_pkg::REG_STATUS: n.rdata = {29'h0000_0000, s.stat};
                sbi_pkg::REG_MASK: n.rdata = {29'h0000_0000, s.mask};
                sbi_pkg::REG_INFO: n.rdata = {16'h0000, 5'(s.cnt_w), s.st, s.sent, s.op, 3'(s.gap)};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        // sticky events, set wins over clear
        n.stat = (s.stat & ~w1c) | ev;
        n.irq = |(n.stat & n.mask);
    end

    // state register
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign REG_RDATA = s.rdata;
    assign IRQ = s.irq;
    assign FILL_VALID = s.fill_v;
    assign FILL_DATA = s.fill_d;
    assign FILL_CHECK = s.fill_c;
    assign FILL_INDEX = s.fill_i;
    assign EXC_CACHE_ERR = s.exc_c;
    assign EXC_BUS_ERR = s.exc_b;
    assign SCLK_OUT = s.sclk;
    assign SYS_ADDR_DATA_BUS_O = s.bus.data;
    assign SYS_ADDR_DATA_BUS_OE = s.bus.oe;
    assign SYS_CHECK_BUS_O = s.bus.chk;
    assign SYS_CHECK_BUS_OE = s.bus.oe;
    assign SYS_VALID_OUT = s.bus.valid;
    assign SYS_CMD_OUT = s.bus.cmd;
    assign SYS_CMD_PARITY = 1'b0;
    assign TDO = TDI;
    assign SLEW_FEEDBACK_OUT = 1'b1;
    assign MISMATCH_FLAG_OUT = 1'b1;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    sequence s_blkw_addr;
        tick && s.st == sbi_pkg::ST_ADDR && s.op == sbi_pkg::CMD_BLKW;
    endsequence
    sequence s_first_data;
        s.st == sbi_pkg::ST_DATA && SYS_VALID_OUT && SYS_CMD_OUT == sbi_pkg::CMD_DATA;
    endsequence

    chk_blkw_no_null: assert property (s_blkw_addr |=> s_first_data)
        else $error("block write data not right after address");
    chk_read_release: assert property (
        tick && s.st == sbi_pkg::ST_ADDR && s.op == sbi_pkg::CMD_READ
        |=> !SYS_ADDR_DATA_BUS_OE && s.st == sbi_pkg::ST_RWAIT)
        else $error("bus not released after read request");
    chk_addr_vtag: assert property (
        s.st == sbi_pkg::ST_ADDR |-> SYS_ADDR_DATA_BUS_O[63:56] == s.vtag && SYS_VALID_OUT)
        else $error("address cycle upper bits wrong");
    chk_nondata_zero: assert property (
        (!SYS_VALID_OUT || SYS_CMD_OUT != sbi_pkg::CMD_DATA) |-> SYS_CHECK_BUS_O == 8'h00)
        else $error("check bits not zero in non-data cycle");
    chk_hold_last: assert property (
        s.st == sbi_pkg::ST_DATA && s.op == sbi_pkg::CMD_BLKW && !SYS_VALID_OUT
        |-> $stable(SYS_ADDR_DATA_BUS_O))
        else $error("idle writeback slot changed bus value");
    chk_wb_no_exc: assert property (s.st != sbi_pkg::ST_RWAIT |-> !EXC_CACHE_ERR)
        else $error("cache error exception outside read");
    chk_late_err: assert property (
        FILL_VALID && FILL_INDEX != 2'h0 |-> !EXC_BUS_ERR && !EXC_CACHE_ERR)
        else $error("exception on later doubleword");
    chk_first_err: assert property (
        FILL_VALID && FILL_INDEX == 2'h0 |-> EXC_BUS_ERR == $past(s.rv_s[1]))
        else $error("first doubleword error bit not honoured");
    chk_write_pace: assert property (
        tick && s.st == sbi_pkg::ST_DATA && s.op == sbi_pkg::CMD_WRITE && !fast
        |=> (s.st == sbi_pkg::ST_GAP && s.gap == 2'h1) [*2])
        else $error("compatible write gap too short");
    chk_wbuf_bound: assert property (
        s.cnt_w <= (PW + 1)'(DEPTH) && (ST_READY == (s.cnt_w != (PW + 1)'(DEPTH))))
        else $error("store buffer count out of range");
    chk_trail_idle: assert property (
        tick && s.st == sbi_pkg::ST_DATA && s.op == sbi_pkg::CMD_BLKW && s.pos != 3'h0
        |=> s.st == sbi_pkg::ST_DATA)
        else $error("writeback ended before pattern end");
    chk_pat_slot: assert property (
        tick && s.st == sbi_pkg::ST_DATA && s.op == sbi_pkg::CMD_BLKW && s.sent < 3'h4
        |=> SYS_VALID_OUT == $past(slot_d))
        else $error("writeback slot does not follow pattern");
    chk_blk_four: assert property (s.sent <= sbi_pkg::BLK_DWORDS)
        else $error("block exceeds four doublewords");
    chk_div_range: assert property (s.cnt <= lim)
        else $error("divider count beyond divisor");
    chk_pins_fixed: assert property (TDO == TDI && SLEW_FEEDBACK_OUT && MISMATCH_FLAG_OUT)
        else $error("fixed pins wrong");
endmodule : sbi_top

/* File: verification/sbi_ctl_model.sv */
`timescale 1ns/1ps
// ----
// system controller model on the multiplexed bus
// ----
module sbi_ctl_model (
    input wire logic clk, // pipeline clock
    input wire logic sclk, // bus clock from device
    input wire logic [63:0] dv, // device data drive
    input wire logic [7:0] dc, // device check drive
    input wire logic oe, // device drives the bus
    input wire logic rq, // read request cycle seen
    input wire logic err0, // error bit for first dword
    input wire logic [3:0] bad, // dwords sent with bad check bits
    output logic [63:0] bus, // data wire level
    output logic [7:0] chk, // check wire level
    output logic rv, // response dword valid
    output logic re // response error bit
);
    logic [63:0] d = '0;
    logic [63:0] last = '0;
    logic [7:0] c = '0;
    logic [7:0] lastc = '0;
    logic drv = 1'b0;

    // even parity per byte
    function automatic logic [7:0] par(input logic [63:0] v);
        for (int i = 0; i < 8; i++) par[i] = ^v[8*i+:8];
    endfunction : par

    // a released wire shows the inverse of its last level
    assign bus = oe ? dv : drv ? d : ~last;
    assign chk = oe ? dc : drv ? c : ~lastc;
    always @(posedge clk) begin
        last <= bus;
        lastc <= chk;
    end

    // four dwords, one per bus period, once the device lets go
    initial begin
        rv = 1'b0;
        re = 1'b0;
        forever begin
            @(posedge clk iff rq);
            @(posedge clk iff !oe);
            @(posedge sclk);
            for (int k = 0; k < 4; k++) begin
                d = {8{8'h30 + 8'(k)}};
                c = par(d) ^ {8{bad[k]}};
                drv = 1'b1;
                rv = 1'b1;
                re = (k == 0) ? err0 : 1'b1;
                @(posedge sclk);
            end
            drv = 1'b0;
            rv = 1'b0;
            re = 1'b0;
        end
    end
endmodule : sbi_ctl_model

/* File: verification/tb_cpu_system_bus_interface.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_cpu_system_bus_interface;
    logic CLK = 0, RSTN = 0, REG_WR = 0, REG_RD = 0, TDI = 0, e0 = 0;
    logic ST_VALID = 0, WB_VALID = 0, RD_VALID = 0;
    logic [3:0] REG_ADDR = 0, WB_BADPAR = 0, bad = 0;
    logic [31:0] REG_WDATA = 0, REG_RDATA;
    logic [35:0] ST_ADDR = 0, WB_ADDR = 0, RD_ADDR = 0;
    logic [7:0] ST_VTAG = 0, WB_VTAG = 0, RD_VTAG = 0, FILL_CHECK, SYS_CHECK_BUS_I, SYS_CHECK_BUS_O;
    logic [63:0] ST_DATA = 0, FILL_DATA, SYS_ADDR_DATA_BUS_I, SYS_ADDR_DATA_BUS_O;
    logic [255:0] WB_DATA = 0;
    logic [1:0] FILL_INDEX, SYS_CMD_OUT;
    logic IRQ, ST_READY, WB_READY, RD_READY, FILL_VALID, EXC_CACHE_ERR, EXC_BUS_ERR, SCLK_OUT;
    logic SYS_ADDR_DATA_BUS_OE, SYS_CHECK_BUS_OE, SYS_VALID_OUT, SYS_CMD_PARITY, RESP_VALID;
    logic RESP_ERR, TDO, SLEW_FEEDBACK_OUT, MISMATCH_FLAG_OUT;
    int fail_count = 0, checks_done = 0, cyc = 0;

    sbi_top u_dut (.*);
    sbi_ctl_model u_ctl (.clk(CLK), .sclk(SCLK_OUT), .dv(SYS_ADDR_DATA_BUS_O),
        .dc(SYS_CHECK_BUS_O), .oe(SYS_ADDR_DATA_BUS_OE), .err0(e0), .bad(bad),
        .rq(SYS_VALID_OUT && SYS_CMD_OUT == sbi_pkg::CMD_READ), .bus(SYS_ADDR_DATA_BUS_I),
        .chk(SYS_CHECK_BUS_I), .rv(RESP_VALID), .re(RESP_ERR));

    // clock and hang limit
    always #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        @(negedge CLK);
        v = REG_RDATA;
    endtask : rd
    task automatic waitfor(ref logic s);
        for (int n = 0; n < 200 && s !== 1'b1; n++) @(negedge CLK);
    endtask : waitfor
    task automatic waitc(input logic [1:0] cm, output int n);
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while (!(SYS_VALID_OUT === 1'b1 && SYS_CMD_OUT === cm) && n < 200);
    endtask : waitc

    task automatic t_pins();
        logic [31:0] v;
        `CHK(SYS_CMD_PARITY, 1'b0)
        `CHK({SLEW_FEEDBACK_OUT, MISMATCH_FLAG_OUT}, 2'b11)
        @(posedge CLK) TDI <= 1'b1;
        @(negedge CLK) `CHK(TDO, 1'b1)
        rd(sbi_pkg::REG_CTRL, v);
        `CHK(v, 32'(sbi_pkg::CTRL_RST))
        rd(4'h2, v);
        `CHK(v, 32'h0000_0000)
        $display("pins and reset values done");
    endtask : t_pins

    task automatic t_store(input logic fast);
        int n;
        wr(sbi_pkg::REG_CTRL, {24'h0, fast, 7'h0});
        fork
            for (int i = 0; i < 4; i++) begin
                @(posedge CLK);
                ST_VALID <= 1'b1;
                ST_DATA <= 64'h0123_4567_89ab_cdef + 64'(i);
                ST_VTAG <= 8'h5a + 8'(i);
                ST_ADDR <= 36'h0_0000_1000 + 36'(i);
                @(negedge CLK) `CHK(ST_READY, 1'b1)
                if (i == 3) @(posedge CLK) ST_VALID <= 1'b0;
            end
            begin
                waitc(sbi_pkg::CMD_WRITE, n);
                `CHK(SYS_ADDR_DATA_BUS_O[63:56], 8'h5a)
                `CHK(SYS_ADDR_DATA_BUS_O[35:0], 36'h0_0000_1000)
                `CHK(SYS_CHECK_BUS_O, 8'h00)
                repeat (2) @(negedge CLK);
                `CHK(SYS_CMD_OUT, sbi_pkg::CMD_DATA)
                `CHK(SYS_CHECK_BUS_O, u_ctl.par(64'h0123_4567_89ab_cdef))
                waitc(sbi_pkg::CMD_WRITE, n);
                `CHK(n + 2, fast ? 4 : 8)
            end
        join
        repeat (80) @(posedge CLK);
        $display("store test done");
    endtask : t_store

    task automatic t_wb();
        logic [63:0] dw, last;
        logic [31:0] v;
        int n, k;
        k = 0;
        wr(sbi_pkg::REG_CTRL, 32'h0000_0010);
        wr(sbi_pkg::REG_MASK, 32'h0000_0004);
        @(posedge CLK);
        WB_VALID <= 1'b1;
        WB_BADPAR <= 4'b0010;
        WB_VTAG <= 8'hc3;
        for (int i = 0; i < 4; i++) WB_DATA[64*i+:64] <= 64'h1111_1111_1111_1111 * (i + 1);
        @(negedge CLK) waitfor(WB_READY);
        @(posedge CLK) WB_VALID <= 1'b0;
        waitc(sbi_pkg::CMD_BLKW, n);
        `CHK(SYS_ADDR_DATA_BUS_O[63:56], 8'hc3)
        for (int p = 1; p < 10; p++) begin
            repeat (2) @(negedge CLK);
            dw = 64'h1111_1111_1111_1111 * (k + 1);
            `CHK(EXC_CACHE_ERR, 1'b0)
            if (p == 9) begin
                `CHK(SYS_ADDR_DATA_BUS_OE, 1'b0)
            end else if (p % 4 == 1 || p % 4 == 2) begin
                `CHK(SYS_VALID_OUT, 1'b1)
                `CHK(SYS_ADDR_DATA_BUS_O, dw)
                `CHK(SYS_CHECK_BUS_O, u_ctl.par(dw) ^ {8{k == 1}})
                last = dw;
                k++;
            end else begin
                `CHK({SYS_VALID_OUT, SYS_ADDR_DATA_BUS_OE, SYS_CHECK_BUS_O}, 10'h100)
                `CHK(SYS_ADDR_DATA_BUS_O, last)
            end
        end
        rd(sbi_pkg::REG_STATUS, v);
        `CHK({v, IRQ}, 33'h0_0000_0009)
        wr(sbi_pkg::REG_MASK, 32'h0000_0000);
        repeat (2) @(negedge CLK) `CHK(IRQ, 1'b0)
        wr(sbi_pkg::REG_STATUS, 32'h0000_0004);
        rd(sbi_pkg::REG_STATUS, v);
        `CHK(v, 32'h0000_0000)
        $display("writeback test done");
    endtask : t_wb

    task automatic t_rd(input logic err, input logic [3:0] b);
        int n;
        e0 = err;
        bad = b;
        wr(sbi_pkg::REG_CTRL, 32'(b));
        @(posedge CLK);
        RD_VALID <= 1'b1;
        RD_VTAG <= 8'h7e;
        @(negedge CLK) waitfor(RD_READY);
        @(posedge CLK) RD_VALID <= 1'b0;
        waitc(sbi_pkg::CMD_READ, n);
        `CHK(SYS_ADDR_DATA_BUS_O[63:56], 8'h7e)
        for (int j = 0; j < b + 3; j++) @(negedge CLK) `CHK(SYS_ADDR_DATA_BUS_OE, j <= b)
        for (int i = 0; i < 4; i++) begin
            @(negedge CLK) waitfor(FILL_VALID);
            `CHK({SCLK_OUT, FILL_INDEX, FILL_DATA}, {1'b1, 2'(i), {8{8'h30 + 8'(i)}}})
            `CHK(FILL_CHECK, u_ctl.par({8{8'h30 + 8'(i)}}) ^ {8{b[i]}})
            `CHK(EXC_BUS_ERR, i == 0 ? err : 1'b0)
            `CHK(EXC_CACHE_ERR, i == 0 ? b[0] : 1'b0)
        end
        repeat (40) @(posedge CLK);
        $display("read test done");
    endtask : t_rd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLK);
        t_pins();
        t_store(1'b0);
        t_store(1'b1);
        t_wb();
        t_rd(1'b1, 4'b0001);
        t_rd(1'b0, 4'b0100);
        tally_and_finish();
    end
endmodule : tb_cpu_system_bus_interface
